// *** dv/rfirq_assertions.sv ***
`timescale 1ns/100ps
// ********
// port checker
// ********
module rfirq_assertions (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	// host register port
	input wire logic       host_start,
	input wire logic [7:0] host_addr,
	input wire logic       host_wr,
	input wire logic       host_rd,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic       host_rvalid,
	// fifo strobes and pin
	input wire logic       fifo_push,
	input wire logic [7:0] fifo_push_data,
	input wire logic       fifo_pop,
	input wire logic       fifo_flush,
	input wire logic       irq_pin_out,
	input wire logic       irq_pin_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_cfg_read;
		host_rd && host_start && host_addr == rfirq_pkg::ADDR_FIFO_CONFIG;
	endsequence
	sequence s_answer;
		host_rvalid;
	endsequence

	chk_push_data: assert property (
		fifo_push |-> $past(host_wr) && fifo_push_data == $past(host_wdata))
		else $error("push without matching write");
	chk_pop_cause: assert property (fifo_pop |-> $past(host_rd))
		else $error("pop without a read");
	chk_read_answer: assert property (host_rd |=> s_answer)
		else $error("read not answered next cycle");
	chk_rvalid_cause: assert property (host_rvalid |-> $past(host_rd))
		else $error("read answer without read");
	chk_flush_cause: assert property (
		fifo_flush |-> $past(host_wr) && ($past(host_wdata) & 8'h10) != 8'h00)
		else $error("flush without flush write");
	chk_flush_reads_zero: assert property (s_cfg_read |=> s_answer ##0 !host_rdata[4])
		else $error("flush bit read as one");
	chk_rdata_hold: assert property (
		!host_rvalid && !$past(rst) |-> $stable(host_rdata))
		else $error("read data moved without answer");
	chk_pin_low_driven: assert property (
		!irq_pin_out && !$past(rst) |-> irq_pin_oe)
		else $error("low pin level not driven");
endmodule

bind rfirq_top rfirq_assertions chk_u (
	.clk_sys, .rst, .host_start, .host_addr, .host_wr, .host_rd, .host_wdata,
	.host_rdata, .host_rvalid, .fifo_push, .fifo_push_data, .fifo_pop, .fifo_flush,
	.irq_pin_out, .irq_pin_oe
);

// *** dv/rfirq_fifo_model.sv ***
`timescale 1ns/100ps
// ********
// fifo storage standing behind the data port
// ********
module rfirq_fifo_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// strobes from the block
	input  wire logic       push,
	input  wire logic [7:0] push_data,
	input  wire logic       pop,
	input  wire logic       flush,
	// show-ahead head byte
	output logic      [7:0] head_data
);
	logic [7:0] mem[$];
	logic [7:0] last;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem.delete();
			last = 8'h00;
		end else if (flush) begin
			mem.delete();
		end else begin
			if (pop && mem.size() > 0) begin
				last = mem.pop_front();
			end
			if (push) begin
				mem.push_back(push_data);
			end
		end
		// empty storage shows the inverse of the last popped byte, never a stale byte
		head_data <= (mem.size() > 0) ? mem[0] : ~last;
	end
endmodule

// *** dv/rfirq_top_tb_top.sv ***
`timescale 1ns/100ps
module rfirq_top_tb_top;
	// ********
	// stimulus, design and partner
	// ********
	logic        clk_sys    = 1'b0;
	logic        rst        = 1'b1;
	logic        host_start = 1'b0;
	logic [7:0]  host_addr  = 8'h00;
	logic        host_wr    = 1'b0;
	logic        host_rd    = 1'b0;
	logic [7:0]  host_wdata = 8'h00;
	logic        host_idle  = 1'b0;
	logic [16:0] evt        = '0;
	logic [7:0]  host_rdata;
	logic        host_rvalid;
	logic        fifo_push;
	logic [7:0]  fifo_push_data;
	logic        fifo_pop;
	logic        fifo_flush;
	logic        fifo_depth_select;
	logic [7:0]  fifo_head_data;
	logic        irq_pin_out;
	logic        irq_pin_oe;
	logic [7:0]  q;
	int          error_cnt   = 0;
	int          comparisons = 0;

	always #2 clk_sys = ~clk_sys;

	rfirq_top dut_u (
		.clk_sys, .rst, .host_start, .host_addr, .host_wr, .host_rd, .host_wdata,
		.host_rdata, .host_rvalid, .fifo_push, .fifo_push_data, .fifo_pop,
		.fifo_flush, .fifo_depth_select, .fifo_head_data,
		.upper_watermark_live(evt[6]), .lower_watermark_live(evt[5]),
		.command_done_event(evt[4]), .command_idle_by_host(host_idle),
		.transmit_done_event(evt[3]), .receive_done_event(evt[2]),
		.frame_start_event(evt[0]), .buffer_write_fault(evt[1]),
		.buffer_overrun_fault(evt[7]), .protocol_fault(evt[8]),
		.empty_send_fault(evt[9]), .integrity_fault(evt[10]),
		.card_presence_event(evt[11]), .counter_expiry_event(evt[16:12]),
		.irq_pin_out, .irq_pin_oe
	);

	rfirq_fifo_model fifo_u (
		.clk_sys, .rst, .push(fifo_push), .push_data(fifo_push_data),
		.pop(fifo_pop), .flush(fifo_flush), .head_data(fifo_head_data)
	);

	task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic acc(input logic st, input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		host_start = st;
		host_addr  = a;
		host_wr    = w;
		host_rd    = !w;
		host_wdata = d;
		@(posedge clk_sys);
		#1;
		host_start = 1'b0;
		host_wr    = 1'b0;
		host_rd    = 1'b0;
		q          = host_rdata;
		if (!w) begin
			cmp8(8'h01, {7'h0, host_rvalid});
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, a, 1'b1, d);
	endtask
	task automatic wrn(input logic [7:0] d);
		acc(1'b0, 8'h00, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a);
		acc(1'b1, a, 1'b0, 8'h00);
	endtask

	task automatic pulse(input int i);
		@(posedge clk_sys);
		#1;
		evt[i] = 1'b1;
		@(posedge clk_sys);
		#1;
		evt[i] = 1'b0;
	endtask

	task automatic pin(input logic o, input logic e);
		repeat (3) @(posedge clk_sys);
		#1;
		cmp8({7'h0, o}, {7'h0, irq_pin_out});
		cmp8({7'h0, e}, {7'h0, irq_pin_oe});
	endtask

	function automatic logic [7:0] exp_bit(input int i);
		if (i < 7) return 8'h01 << i;
		if (i < 11) return 8'h02;
		if (i == 11) return 8'h20;
		return 8'h01 << (i - 12);
	endfunction

	task automatic t_reset();
		rd(rfirq_pkg::ADDR_FILL_COUNT);
		cmp8(8'h00, q);
		rd(rfirq_pkg::ADDR_REQ_PRI);
		cmp8(8'h00, q & 8'h7f);
		pin(1'b0, 1'b1);
		$display("t_reset done");
	endtask

	task automatic t_fifo();
		wr(rfirq_pkg::ADDR_DATA_PORT, 8'ha1);
		wrn(8'hb2);
		wrn(8'hc3);
		rd(rfirq_pkg::ADDR_FILL_COUNT);
		cmp8(8'h03, q);
		rd(rfirq_pkg::ADDR_DATA_PORT);
		cmp8(8'ha1, q);
		acc(1'b0, 8'h00, 1'b0, 8'h00);
		cmp8(8'hb2, q);
		acc(1'b0, 8'h00, 1'b0, 8'h00);
		cmp8(8'hc3, q);
		rd(rfirq_pkg::ADDR_FILL_COUNT);
		cmp8(8'h00, q);
		rd(rfirq_pkg::ADDR_DATA_PORT);
		rd(rfirq_pkg::ADDR_FILL_COUNT);
		cmp8(8'h00, q);
		// 257 bytes reach past the 8-bit count into the high bits
		wr(rfirq_pkg::ADDR_DATA_PORT, 8'h00);
		for (int i = 1; i < 257; i++) begin
			wrn(8'(i));
		end
		rd(rfirq_pkg::ADDR_FILL_COUNT);
		cmp8(8'h01, q);
		rd(rfirq_pkg::ADDR_FIFO_CONFIG);
		cmp8(8'h01, q & 8'h13);
		wr(rfirq_pkg::ADDR_FIFO_CONFIG, 8'h10);
		rd(rfirq_pkg::ADDR_FILL_COUNT);
		cmp8(8'h00, q);
		rd(rfirq_pkg::ADDR_FIFO_CONFIG);
		cmp8(8'h00, q & 8'h13);
		// small mode: the byte past 255 is refused, high bits read zero
		wr(rfirq_pkg::ADDR_FIFO_CONFIG, 8'h80);
		cmp8(8'h01, {7'h0, fifo_depth_select});
		wr(rfirq_pkg::ADDR_DATA_PORT, 8'h00);
		for (int i = 1; i < 256; i++) begin
			wrn(8'(i));
		end
		rd(rfirq_pkg::ADDR_FILL_COUNT);
		cmp8(8'hff, q);
		rd(rfirq_pkg::ADDR_FIFO_CONFIG);
		cmp8(8'h80, q & 8'h93);
		wr(rfirq_pkg::ADDR_FIFO_CONFIG, 8'h10);
		cmp8(8'h00, {7'h0, fifo_depth_select});
		$display("t_fifo done");
	endtask

	task automatic t_pointer();
		wr(rfirq_pkg::ADDR_EN_PRI, 8'h12);
		wrn(8'h40);
		rd(rfirq_pkg::ADDR_EN_PRI);
		cmp8(8'h12, q);
		rd(rfirq_pkg::ADDR_EN_SEC);
		cmp8(8'h40, q);
		wr(rfirq_pkg::ADDR_EN_PRI, 8'h00);
		wrn(8'h00);
		rd(8'h0f);
		cmp8(8'h00, q);
		$display("t_pointer done");
	endtask

	task automatic t_events();
		logic [7:0] a;
		for (int i = 0; i < 17; i++) begin
			a = (i < 11) ? rfirq_pkg::ADDR_REQ_PRI : rfirq_pkg::ADDR_REQ_SEC;
			pulse(i);
			rd(a);
			cmp8(exp_bit(i), q & 8'h7f);
			wr(a, 8'h7f);
			rd(a);
			cmp8(8'h00, q & 8'h7f);
		end
		host_idle = 1'b1;
		pulse(4);
		host_idle = 1'b0;
		rd(rfirq_pkg::ADDR_REQ_PRI);
		cmp8(8'h00, q & 8'h7f);
		wr(rfirq_pkg::ADDR_REQ_PRI, 8'hff);
		wr(rfirq_pkg::ADDR_REQ_PRI, 8'h05);
		rd(rfirq_pkg::ADDR_REQ_PRI);
		cmp8(8'h7a, q & 8'h7f);
		wr(rfirq_pkg::ADDR_REQ_PRI, 8'h7f);
		wr(rfirq_pkg::ADDR_REQ_SEC, 8'hff);
		rd(rfirq_pkg::ADDR_REQ_SEC);
		cmp8(8'h3f, q & 8'h7f);
		wr(rfirq_pkg::ADDR_REQ_SEC, 8'h3f);
		$display("t_events done");
	endtask

	task automatic t_global();
		wr(rfirq_pkg::ADDR_EN_PRI, 8'h08);
		wr(rfirq_pkg::ADDR_EN_SEC, 8'h40);
		pulse(3);
		rd(rfirq_pkg::ADDR_REQ_SEC);
		cmp8(8'h40, q & 8'h40);
		// open drain: a high level is released, not driven
		pin(1'b1, 1'b0);
		wr(rfirq_pkg::ADDR_REQ_PRI, 8'h08);
		pin(1'b0, 1'b1);
		wr(rfirq_pkg::ADDR_EN_PRI, 8'h00);
		pulse(3);
		pin(1'b0, 1'b1);
		wr(rfirq_pkg::ADDR_EN_PRI, 8'h88);
		pin(1'b0, 1'b1);
		wr(rfirq_pkg::ADDR_EN_PRI, 8'h80);
		pin(1'b1, 1'b0);
		wr(rfirq_pkg::ADDR_EN_SEC, 8'h00);
		wr(rfirq_pkg::ADDR_EN_PRI, 8'h08);
		pin(1'b0, 1'b1);
		wr(rfirq_pkg::ADDR_REQ_PRI, 8'h7f);
		wr(rfirq_pkg::ADDR_EN_PRI, 8'h00);
		wr(rfirq_pkg::ADDR_EN_SEC, 8'hc1);
		pulse(12);
		pin(1'b1, 1'b1);
		wr(rfirq_pkg::ADDR_REQ_SEC, 8'h3f);
		pin(1'b0, 1'b1);
		$display("t_global done");
	endtask

	task automatic t_rerst();
		wr(rfirq_pkg::ADDR_REQ_PRI, 8'hff);
		wr(rfirq_pkg::ADDR_DATA_PORT, 8'h5a);
		// reset in mid-run must drop flags, count and enables
		@(posedge clk_sys);
		#1;
		rst = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		rd(rfirq_pkg::ADDR_FILL_COUNT);
		cmp8(8'h00, q);
		rd(rfirq_pkg::ADDR_REQ_PRI);
		cmp8(8'h00, q);
		rd(rfirq_pkg::ADDR_EN_SEC);
		cmp8(8'h00, q);
		pin(1'b0, 1'b1);
		$display("t_rerst done");
	endtask

	task automatic give_verdict();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_reset();
		t_fifo();
		t_pointer();
		t_events();
		t_global();
		t_rerst();
		give_verdict();
	end

	// run needs under 2000 cycles; this allows more than ten times that
	initial begin
		#100000;
		error_cnt++;
		give_verdict();
	end
endmodule

// *** hw/rfirq_flag_if.sv ***
`timescale 1ns/100ps
interface rfirq_flag_if #(
	parameter int W = 7
) (
	input wire logic clk_sys,
	input wire logic rst
);
	logic         wr;
	logic         set_mode;
	logic [W-1:0] sel;
	logic [W-1:0] evt;
	logic [W-1:0] flags;

	modport ctl (
		output wr,
		output set_mode,
		output sel,
		output evt,
		input  flags
	);

	modport regs (
		input  clk_sys,
		input  rst,
		input  wr,
		input  set_mode,
		input  sel,
		input  evt,
		output flags
	);
endinterface

// *** hw/rfirq_flag_reg.sv ***
`timescale 1ns/100ps
module rfirq_flag_reg #(
	parameter int           W       = 7,
	parameter logic [W-1:0] RST_VAL = '0
) (
	rfirq_flag_if.regs bus
);
	logic [W-1:0] next_flags;

	always_comb begin
		next_flags = bus.flags;
		if (bus.wr && bus.set_mode) begin
			next_flags = next_flags | bus.sel;
		end else if (bus.wr) begin
			next_flags = next_flags & ~bus.sel;
		end
		// an event in the clearing cycle still lands
		next_flags = next_flags | bus.evt;
	end

	always_ff @(posedge bus.clk_sys or posedge bus.rst) begin
		if (bus.rst) begin
			bus.flags <= RST_VAL;
		end else begin
			bus.flags <= next_flags;
		end
	end
endmodule

// *** hw/rfirq_pkg.sv ***
package rfirq_pkg;

	// ****************************************************************
	// register offsets on the host register port
	// ****************************************************************
	localparam logic [7:0] ADDR_FIFO_CONFIG = 8'h02;
	localparam logic [7:0] ADDR_FILL_COUNT  = 8'h04;
	localparam logic [7:0] ADDR_DATA_PORT   = 8'h05;
	localparam logic [7:0] ADDR_REQ_PRI     = 8'h06;
	localparam logic [7:0] ADDR_REQ_SEC     = 8'h07;
	localparam logic [7:0] ADDR_EN_PRI      = 8'h08;
	localparam logic [7:0] ADDR_EN_SEC      = 8'h09;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int PRI_FLAGS = 7;
	localparam int SEC_FLAGS = 6;
	localparam int COUNT_W   = 10;
	localparam int FAULT_W   = 5;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CFG_DEPTH_BIT  = 7;
	localparam int CFG_UPPER_BIT  = 6;
	localparam int CFG_LOWER_BIT  = 5;
	localparam int CFG_FLUSH_BIT  = 4;
	localparam int SET_MODE_BIT   = 7;
	localparam int SEC_GLOBAL_BIT = 6;
	localparam int EN_INVERT_BIT  = 7;
	localparam int EN_PUSHPULL_BIT = 7;
	localparam int EN_PIN_GATE_BIT = 6;
	// primary request flag positions
	localparam int PRI_UPPER_BIT  = 6;
	localparam int PRI_LOWER_BIT  = 5;
	localparam int PRI_DONE_BIT   = 4;
	localparam int PRI_TX_BIT     = 3;
	localparam int PRI_RX_BIT     = 2;
	localparam int PRI_FAULT_BIT  = 1;
	localparam int PRI_SOF_BIT    = 0;
	// secondary request flag positions
	localparam int SEC_CARD_BIT   = 5;

	// ****************************************************************
	// reset values and fifo depths
	// ****************************************************************
	localparam logic [COUNT_W-1:0]   RST_FILL_COUNT = 10'h000;
	localparam logic [PRI_FLAGS-1:0] RST_REQ_PRI    = 7'h00;
	localparam logic [SEC_FLAGS-1:0] RST_REQ_SEC    = 6'h00;
	localparam logic [7:0]           RST_EN         = 8'h00;
	localparam logic                 RST_DEPTH_SEL  = 1'b0;
	localparam logic [COUNT_W-1:0]   DEPTH_SMALL    = 10'h0ff;
	localparam logic [COUNT_W-1:0]   DEPTH_LARGE    = 10'h200;

endpackage

// *** hw/rfirq_top.sv ***
`timescale 1ns/100ps
module rfirq_top (
	// clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rst,
	// host register port
	input  wire logic                              host_start,
	input  wire logic [7:0]                        host_addr,
	input  wire logic                              host_wr,
	input  wire logic                              host_rd,
	input  wire logic [7:0]                        host_wdata,
	output logic      [7:0]                        host_rdata,
	output logic                                   host_rvalid,
	// fifo storage outside
	output logic                                   fifo_push,
	output logic      [7:0]                        fifo_push_data,
	output logic                                   fifo_pop,
	output logic                                   fifo_flush,
	output logic                                   fifo_depth_select,
	input  wire logic [7:0]                        fifo_head_data,
	// live watermark levels
	input  wire logic                              upper_watermark_live,
	input  wire logic                              lower_watermark_live,
	// transceiver events
	input  wire logic                              command_done_event,
	input  wire logic                              command_idle_by_host,
	input  wire logic                              transmit_done_event,
	input  wire logic                              receive_done_event,
	input  wire logic                              frame_start_event,
	// fault levels
	input  wire logic                              buffer_write_fault,
	input  wire logic                              buffer_overrun_fault,
	input  wire logic                              protocol_fault,
	input  wire logic                              empty_send_fault,
	input  wire logic                              integrity_fault,
	// card detection and timers
	input  wire logic                              card_presence_event,
	input  wire logic [4:0]                        counter_expiry_event,
	// interrupt pin
	output logic                                   irq_pin_out,
	output logic                                   irq_pin_oe
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [7:0]                             addr_ptr;
	logic [7:0]                             next_addr_ptr;
	logic [7:0]                             acc_addr;
	logic                                   acc_any;
	logic                                   wr_data_port;
	logic                                   rd_data_port;
	logic                                   wr_config;
	logic                                   flush_req;
	logic [rfirq_pkg::COUNT_W-1:0]          fill_count;
	logic [rfirq_pkg::COUNT_W-1:0]          next_fill_count;
	logic [rfirq_pkg::COUNT_W-1:0]          depth_limit;
	logic                                   push_ok;
	logic                                   pop_ok;
	logic [1:0]                             count_high;
	logic [7:0]                             request_enable_primary;
	logic [7:0]                             request_enable_secondary;
	logic                                   combined_request;
	logic                                   next_combined;
	logic                                   pin_level;
	logic                                   upper_prev;
	logic                                   lower_prev;
	logic [rfirq_pkg::FAULT_W-1:0]          fault_vec;
	logic [rfirq_pkg::FAULT_W-1:0]          fault_prev;
	logic                                   fault_rise;
	logic [rfirq_pkg::PRI_FLAGS-1:0]        pri_evt;
	logic [rfirq_pkg::SEC_FLAGS-1:0]        sec_evt;
	logic [7:0]                             next_rdata;

	rfirq_flag_if #(.W(rfirq_pkg::PRI_FLAGS)) pri_if (
		.clk_sys (clk_sys),
		.rst     (rst)
	);
	rfirq_flag_if #(.W(rfirq_pkg::SEC_FLAGS)) sec_if (
		.clk_sys (clk_sys),
		.rst     (rst)
	);

	// ****************************************************************
	// address pointer
	// ****************************************************************
	// a start pulse may carry its own first access
	assign acc_addr = host_start ? host_addr : addr_ptr;
	assign acc_any  = host_wr | host_rd;

	always_comb begin
		next_addr_ptr = acc_addr;
		if (acc_any && (acc_addr != rfirq_pkg::ADDR_DATA_PORT)) begin
			next_addr_ptr = acc_addr + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			addr_ptr <= 8'h00;
		end else begin
			addr_ptr <= next_addr_ptr;
		end
	end

	// ****************************************************************
	// access decode
	// ****************************************************************
	assign wr_data_port = host_wr && (acc_addr == rfirq_pkg::ADDR_DATA_PORT);
	assign rd_data_port = host_rd && (acc_addr == rfirq_pkg::ADDR_DATA_PORT);
	assign wr_config    = host_wr && (acc_addr == rfirq_pkg::ADDR_FIFO_CONFIG);
	assign flush_req    = wr_config && host_wdata[rfirq_pkg::CFG_FLUSH_BIT];

	// ****************************************************************
	// fill count
	// ****************************************************************
	assign depth_limit = fifo_depth_select ? rfirq_pkg::DEPTH_SMALL : rfirq_pkg::DEPTH_LARGE;
	// full and empty refuse the access so the count stays honest
	assign push_ok     = wr_data_port && (fill_count < depth_limit);
	assign pop_ok      = rd_data_port && (fill_count != '0);

	always_comb begin
		next_fill_count = fill_count;
		if (flush_req) begin
			next_fill_count = '0;
		end else if (push_ok) begin
			next_fill_count = fill_count + 10'h001;
		end else if (pop_ok) begin
			next_fill_count = fill_count - 10'h001;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fill_count <= rfirq_pkg::RST_FILL_COUNT;
		end else begin
			fill_count <= next_fill_count;
		end
	end

	// high bits only in large mode
	assign count_high = fifo_depth_select ? 2'h0 : fill_count[9:8];

	// ****************************************************************
	// fifo strobes and configuration
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fifo_push      <= 1'b0;
			fifo_push_data <= 8'h00;
			fifo_pop       <= 1'b0;
			fifo_flush     <= 1'b0;
		end else begin
			fifo_push      <= push_ok && !flush_req;
			fifo_push_data <= host_wdata;
			fifo_pop       <= pop_ok;
			fifo_flush     <= flush_req;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fifo_depth_select <= rfirq_pkg::RST_DEPTH_SEL;
		end else if (wr_config) begin
			fifo_depth_select <= host_wdata[rfirq_pkg::CFG_DEPTH_BIT];
		end
	end

	// ****************************************************************
	// enable registers
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			request_enable_primary   <= rfirq_pkg::RST_EN;
			request_enable_secondary <= rfirq_pkg::RST_EN;
		end else begin
			if (host_wr && (acc_addr == rfirq_pkg::ADDR_EN_PRI)) begin
				request_enable_primary <= host_wdata;
			end
			if (host_wr && (acc_addr == rfirq_pkg::ADDR_EN_SEC)) begin
				request_enable_secondary <= host_wdata;
			end
		end
	end

	// ****************************************************************
	// event edge detection
	// ****************************************************************
	assign fault_vec = {buffer_write_fault, buffer_overrun_fault, protocol_fault,
			empty_send_fault, integrity_fault};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			upper_prev <= 1'b0;
			lower_prev <= 1'b0;
			fault_prev <= '0;
		end else begin
			upper_prev <= upper_watermark_live;
			lower_prev <= lower_watermark_live;
			fault_prev <= fault_vec;
		end
	end

	assign fault_rise = |(fault_vec & ~fault_prev);

	always_comb begin
		pri_evt = '0;
		pri_evt[rfirq_pkg::PRI_UPPER_BIT] = upper_watermark_live && !upper_prev;
		pri_evt[rfirq_pkg::PRI_LOWER_BIT] = lower_watermark_live && !lower_prev;
		pri_evt[rfirq_pkg::PRI_DONE_BIT]  = command_done_event && !command_idle_by_host;
		pri_evt[rfirq_pkg::PRI_TX_BIT]    = transmit_done_event;
		pri_evt[rfirq_pkg::PRI_RX_BIT]    = receive_done_event;
		pri_evt[rfirq_pkg::PRI_FAULT_BIT] = fault_rise;
		pri_evt[rfirq_pkg::PRI_SOF_BIT]   = frame_start_event;
	end

	always_comb begin
		sec_evt = {1'b0, counter_expiry_event};
		sec_evt[rfirq_pkg::SEC_CARD_BIT] = card_presence_event;
	end

	// ****************************************************************
	// request flag registers
	// ****************************************************************
	// primary set/clear write
	assign pri_if.wr       = host_wr && (acc_addr == rfirq_pkg::ADDR_REQ_PRI);
	assign pri_if.set_mode = host_wdata[rfirq_pkg::SET_MODE_BIT];
	assign pri_if.sel      = host_wdata[rfirq_pkg::PRI_FLAGS-1:0];
	assign pri_if.evt      = pri_evt;

	assign sec_if.wr       = host_wr && (acc_addr == rfirq_pkg::ADDR_REQ_SEC);
	assign sec_if.set_mode = host_wdata[rfirq_pkg::SET_MODE_BIT];
	assign sec_if.sel      = host_wdata[rfirq_pkg::SEC_FLAGS-1:0];
	assign sec_if.evt      = sec_evt;

	rfirq_flag_reg #(
		.W       (rfirq_pkg::PRI_FLAGS),
		.RST_VAL (rfirq_pkg::RST_REQ_PRI)
	) u_req_pri (
		.bus (pri_if)
	);

	rfirq_flag_reg #(
		.W       (rfirq_pkg::SEC_FLAGS),
		.RST_VAL (rfirq_pkg::RST_REQ_SEC)
	) u_req_sec (
		.bus (sec_if)
	);

	// ****************************************************************
	// global request and pin
	// ****************************************************************
	// enabled flags OR'd
	assign next_combined =
		|(pri_if.flags & request_enable_primary[rfirq_pkg::PRI_FLAGS-1:0]) |
		|(sec_if.flags & request_enable_secondary[rfirq_pkg::SEC_FLAGS-1:0]);

	assign pin_level =
		(next_combined && request_enable_secondary[rfirq_pkg::EN_PIN_GATE_BIT]) ^
		request_enable_primary[rfirq_pkg::EN_INVERT_BIT];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			combined_request <= 1'b0;
		end else begin
			combined_request <= next_combined;
		end
	end

	// open drain only pulls low, so high leaves the pin released
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_pin_out <= 1'b0;
			irq_pin_oe  <= 1'b0;
		end else begin
			irq_pin_out <= pin_level;
			irq_pin_oe  <= request_enable_secondary[rfirq_pkg::EN_PUSHPULL_BIT] || !pin_level;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	always_comb begin
		next_rdata = 8'h00;
		unique case (acc_addr)
			rfirq_pkg::ADDR_FIFO_CONFIG: begin
				next_rdata = {fifo_depth_select, upper_watermark_live, lower_watermark_live,
						3'h0, count_high};
			end
			rfirq_pkg::ADDR_FILL_COUNT: begin
				next_rdata = fill_count[7:0];
			end
			rfirq_pkg::ADDR_DATA_PORT: begin
				next_rdata = fifo_head_data;
			end
			rfirq_pkg::ADDR_REQ_PRI: begin
				next_rdata = {1'b0, pri_if.flags};
			end
			rfirq_pkg::ADDR_REQ_SEC: begin
				next_rdata = {1'b0, combined_request, sec_if.flags};
			end
			rfirq_pkg::ADDR_EN_PRI: begin
				next_rdata = request_enable_primary;
			end
			rfirq_pkg::ADDR_EN_SEC: begin
				next_rdata = request_enable_secondary;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			host_rdata  <= 8'h00;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_rd;
			if (host_rd) begin
				host_rdata <= next_rdata;
			end
		end
	end

endmodule
